//--- rtl/usms_spi.sv
/*
  Master SPI transfer controller of the serial port: mode decode, clock
  generation, transmit and receive shifters with their buffers.
  Assumes software drives the configuration ports steadily during frames and
  that the pins are resolved by the surroundings from the enables.
*/
// Overview of operation
// - Master SPI only when mode field is 11
// - Controller owns shifters, buffers and baud generator
// - No parity, recovery or async control here
// - Pin control and event flags as usual
// - Same ports; some config bits change meaning
// - Clock is generated internally only, never slave
// - Bit rate is fclk over 2(divisor+1)
// - Divisor is 12 bits from high and low
// - Divisor zero gives half system clock
// - Full duplex over output, input and clock
// - All four polarity/phase modes supported
// - Bit order selectable, LSB or MSB first
// - Transmit and receive double buffered
// - Shift and sample on opposite edges per mode
// - Eight bit frames, back to back allowed
// - Data write starts send, and receive when receiver enabled
// - Receive overflow drops the newest byte
`timescale 1ns/1ps
`default_nettype none

module usms_spi
  import usms_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               SRST,
  // Configuration
  input  wire usms_pkg::usms_cfg_t CFG,
  // Data port, write side
  input  wire logic               WR_STB,
  input  wire logic [7:0]         WR_DATA,
  // Data port, read side
  input  wire logic               RD_STB,
  output var  logic [7:0]         RD_DATA,
  // Flag clears
  input  wire logic               TXC_CLR,
  input  wire logic               OVR_CLR,
  // Status
  output var  usms_pkg::usms_status_t STATUS,
  // Pins
  output var  logic               TXD_OUT,
  output var  logic               TXD_OE_N,
  input  wire logic               RXD_IN,
  output var  logic               SCK_OUT,
  output var  logic               SCK_OE_N
);

  import usms_pkg::*;

  typedef struct packed {
    usms_state_t     st;
    logic [3:0]      half;
    logic            tgl;
    logic [7:0]      tsr;
    logic [7:0]      txb;
    logic            txf;
    logic [7:0]      rsr;
    logic [1:0][7:0] rxb;
    logic [1:0]      rxc;
    logic            rxv;
    logic            txc;
    logic            ovr;
    logic            mosi;
    logic            sck;
    logic            sck_oe_n;
    logic            txd_oe_n;
  } usms_core_t;

  usms_core_t q;
  usms_core_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and divisor
  logic        mspi;
  logic [11:0] div;
  logic        tick;
  logic        frame_end;
  logic        setup_edge;
  logic        sample_edge;
  logic        rx_push;

  // Control bits take their SPI meaning only in this mode
  assign mspi = (CFG.port_mode_select_field == MODE_MSPI)
                && CFG.transmitter_enable_bit;
  assign div  = {CFG.baud_divisor_high, CFG.baud_divisor_low};

  // Shared generator, no clock input path exists
  usms_baud #(.W(DIV_W)) u_baud (
    .CLK  (CLK),
    .SRST (SRST),
    .en   (q.st == USMS_SHIFT),
    .div  (div),
    .tick (tick)
  );

  assign frame_end   = tick && (q.half == HALF_LAST);
  assign setup_edge  = tick && (q.half[0] != CFG.clock_phase_bit);
  assign sample_edge = tick && (q.half[0] == CFG.clock_phase_bit);
  assign rx_push     = frame_end && CFG.receiver_enable_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Bit order helpers
  function automatic logic first_bit(input logic [7:0] v, input logic lsb);
    first_bit = lsb ? v[0] : v[7];
  endfunction : first_bit

  function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction : shift_out

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////
  // Single transfer controller; no parity or recovery logic exists here
  always_comb
  begin
    logic [7:0] rnew;
    logic [1:0] cnt;
    logic       load;
    rnew = q.rsr;
    cnt  = q.rxc;
    load = 1'b0;
    d    = q;

    // Transmit buffer accepts a byte while empty, or in the cycle its byte loads the shifter
    if (mspi && WR_STB && !q.txf)
    begin
      d.txb = WR_DATA;
      d.txf = 1'b1;
    end

    unique case (q.st)
      USMS_IDLE:
      begin
        d.tgl = 1'b0;
        if (mspi && q.txf)
          load = 1'b1;
      end
      USMS_SHIFT:
      begin
        if (sample_edge)
          rnew = shift_in(q.rsr, CFG.bit_order_select, RXD_IN);
        d.rsr = rnew;
        if (setup_edge && !frame_end)
        begin
          d.mosi = first_bit(q.tsr, CFG.bit_order_select);
          d.tsr  = shift_out(q.tsr, CFG.bit_order_select);
        end
        if (tick)
        begin
          d.tgl  = ~q.tgl;
          d.half = q.half + 1'b1;
        end
        if (frame_end)
        begin
          if (q.txf)
            load = 1'b1;
          else
          begin
            d.st  = USMS_IDLE;
            d.txc = 1'b1;
          end
        end
      end
    endcase

    // Leaving the mode aborts the frame and parks the clock
    if (!mspi)
    begin
      d.st   = USMS_IDLE;
      d.tgl  = 1'b0;
      d.half = HALF_RST;
      load   = 1'b0;
    end

    if (load)
    begin
      d.st   = USMS_SHIFT;
      d.half = HALF_RST;
      d.tgl  = 1'b0;
      d.txf  = WR_STB;
      d.txb  = WR_STB ? WR_DATA : q.txb;
      if (CFG.clock_phase_bit)
      begin
        d.tsr = q.txb;
      end
      else
      begin
        d.mosi = first_bit(q.txb, CFG.bit_order_select);
        d.tsr  = shift_out(q.txb, CFG.bit_order_select);
      end
    end

    // Receive buffer: pop before push so a read frees room in the same cycle
    if (RD_STB && cnt != RXC_RST)
    begin
      d.rxb[0] = q.rxb[1];
      cnt      = cnt - 1'b1;
    end
    if (rx_push)
    begin
      if (cnt == RXC_FULL)
        d.ovr = 1'b1;
      else
      begin
        d.rxb[cnt[0]] = rnew;
        cnt           = cnt + 1'b1;
      end
    end
    d.rxc = cnt;
    d.rxv = (cnt != RXC_RST);

    // Set wins over clear for both sticky flags
    if (TXC_CLR && !(frame_end && !q.txf))
      d.txc = 1'b0;
    if (OVR_CLR && !(rx_push && cnt == RXC_FULL && q.rxc == RXC_FULL))
      d.ovr = 1'b0;

    // Pin control as in the ordinary port; driven means enable low
    d.sck      = CFG.clock_polarity_bit ^ d.tgl;
    d.sck_oe_n = ~(mspi && CFG.clock_pin_direction_bit);
    d.txd_oe_n = ~mspi;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      q          <= '0;
      q.st       <= USMS_IDLE;
      q.sck_oe_n <= 1'b1;
      q.txd_oe_n <= 1'b1;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign RD_DATA                       = q.rxb[0];
  assign STATUS.tx_empty               = ~q.txf;
  assign STATUS.transmit_complete_flag = q.txc;
  assign STATUS.receive_complete_flag  = q.rxv;
  assign STATUS.rx_overrun             = q.ovr;
  assign TXD_OUT                       = q.mosi;
  assign SCK_OUT                       = q.sck;
  assign SCK_OE_N                      = q.sck_oe_n;
  assign TXD_OE_N                      = q.txd_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_mode_gate: assert property (@(posedge CLK) disable iff (SRST)
    !mspi |=> (q.st == USMS_IDLE) && !q.tgl)
    else $error("shifting outside master SPI mode");

  a_clock_idle: assert property (@(posedge CLK) disable iff (SRST)
    (q.st == USMS_IDLE && $stable(CFG.clock_polarity_bit))
      |-> (SCK_OUT == CFG.clock_polarity_bit) || $past(q.st == USMS_SHIFT) || $past(SRST))
    else $error("clock not at idle level between frames");

  a_frame_length: assert property (@(posedge CLK) disable iff (SRST)
    frame_end |-> q.tgl)
    else $error("frame ended on wrong half period");

  a_write_start: assert property (@(posedge CLK) disable iff (SRST)
    (mspi && WR_STB && !q.txf && q.st == USMS_IDLE)
      ##1 (mspi && !WR_STB) |=> (q.st == USMS_SHIFT))
    else $error("data write did not start a frame");

  a_gapless: assert property (@(posedge CLK) disable iff (SRST)
    (frame_end && q.txf && mspi) |=> (q.st == USMS_SHIFT) && (q.half == HALF_RST))
    else $error("queued byte not started back to back");

  a_rx_overflow: assert property (@(posedge CLK) disable iff (SRST)
    (rx_push && q.rxc == RXC_FULL && !RD_STB)
      |=> (q.rxc == RXC_FULL) && $stable(q.rxb) && q.ovr)
    else $error("overflow did not keep older bytes");

  a_tx_complete: assert property (@(posedge CLK) disable iff (SRST)
    (frame_end && !q.txf) |=> STATUS.transmit_complete_flag && (q.st == USMS_IDLE))
    else $error("transmit complete flag not set");

  c_one_frame:  cover property (@(posedge CLK) disable iff (SRST)
    frame_end && !q.txf);
  c_back2back:  cover property (@(posedge CLK) disable iff (SRST)
    frame_end && q.txf);
  c_overflow:   cover property (@(posedge CLK) disable iff (SRST)
    rx_push && q.rxc == RXC_FULL);
  c_mode3:      cover property (@(posedge CLK) disable iff (SRST)
    frame_end && CFG.clock_phase_bit && CFG.clock_polarity_bit);

endmodule : usms_spi

`default_nettype wire

//--- shared/usms_pkg.sv
/*
  Shared constants and types of the serial port in master SPI operation.
  Assumes a single 20 MHz system clock and a synchronous active-high reset.
*/
package usms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and divisor
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned DIV_W       = 12;
  localparam logic [11:0] DIV_RST     = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and frame
  localparam logic [1:0]  MODE_MSPI   = 2'h3;
  localparam int unsigned FRAME_BITS  = 8;
  localparam logic [3:0]  HALF_LAST   = 4'hF;
  localparam logic [3:0]  HALF_RST    = 4'h0;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [1:0]  RXC_FULL    = 2'h2;
  localparam logic [1:0]  RXC_RST     = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    USMS_IDLE  = 2'b01,
    USMS_SHIFT = 2'b10
  } usms_state_t;

  typedef struct packed {
    logic [1:0]  port_mode_select_field;
    logic        transmitter_enable_bit;
    logic        receiver_enable_bit;
    logic        clock_polarity_bit;
    logic        clock_phase_bit;
    logic        bit_order_select;        // 1: least significant bit first
    logic        clock_pin_direction_bit; // 1: clock pin is an output
    logic [3:0]  baud_divisor_high;
    logic [7:0]  baud_divisor_low;
  } usms_cfg_t;

  typedef struct packed {
    logic        tx_empty;
    logic        transmit_complete_flag;
    logic        receive_complete_flag;
    logic        rx_overrun;
  } usms_status_t;

endpackage : usms_pkg

//--- rtl/usms_baud.sv
/*
  Baud generator: one tick per half bit period of div+1 system clocks.
  Assumes the divisor is held steady while a frame is shifting.
*/
`timescale 1ns/1ps
`default_nettype none

module usms_baud
  import usms_pkg::*;
#(
  parameter int unsigned W = DIV_W
)
(
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         SRST,
  // Control
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  // Half period strobe
  output var  logic         tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } usms_baud_st_t;

  usms_baud_st_t s_q;
  usms_baud_st_t s_d;

  // Compare with >= so that a divisor lowered mid-count cannot stall the count
  always_comb
  begin
    s_d  = s_q;
    tick = en && (s_q.cnt >= div);
    if (!en || tick)
      s_d.cnt = '0;
    else
      s_d.cnt = s_q.cnt + 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_half_period: assert property (@(posedge CLK) disable iff (SRST)
    (tick && div != '0 && $stable(div) && en) |=> !tick)
    else $error("baud tick repeated with nonzero divisor");

  a_max_rate: assert property (@(posedge CLK) disable iff (SRST)
    (en && $past(en) && div == '0 && $past(div) == '0) |-> tick)
    else $error("divisor zero did not tick every cycle");

endmodule : usms_baud

`default_nettype wire

//--- testbench/usms_slave.sv
/*
  Behavioural SPI slave on the three wires of the master port.
  Assumes it is reset together with the master whenever the mode changes.
*/
`timescale 1ns/1ps
`default_nettype none

module usms_slave
  import usms_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Mode
  input  wire usms_pkg::usms_cfg_t cfg,
  // Wires
  input  wire logic                sck,
  input  wire logic                mosi,
  output var  logic                miso,
  // Observed byte
  output var  logic                got_stb,
  output var  logic [7:0]          got
);
  logic [1:0] hold_q;
  logic       sck_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] cur_q;
  logic [7:0] sh_d;
  logic       smp;

  ////////////////////////////////////////////////////////////////////////////
  // Sample edge is rising when polarity equals phase; idle settling ignored
  assign smp  = (sck != sck_q) && (hold_q == 2'h0)
                && (sck == (cfg.clock_polarity_bit == cfg.clock_phase_bit));
  assign sh_d = cfg.bit_order_select ? {mosi, sh_q[7:1]} : {sh_q[6:0], mosi};
  // Answer changes right after the sample edge: no extra hold given
  assign miso = cfg.bit_order_select ? cur_q[cnt_q] : cur_q[3'h7 - cnt_q];

  always_ff @(posedge clk)
  begin
    got_stb <= 1'b0;
    sck_q   <= sck;
    if (srst)
    begin
      hold_q <= 2'h3;
      cnt_q  <= 3'h0;
      cur_q  <= 8'h3C;
    end
    else
    begin
      if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
      if (smp)
      begin
        cnt_q <= cnt_q + 3'h1;
        sh_q  <= sh_d;
        if (cnt_q == 3'h7)
        begin
          got     <= sh_d;
          got_stb <= 1'b1;
          cur_q   <= sh_d ^ 8'h5A;
        end
      end
    end
  end
endmodule : usms_slave
`default_nettype wire

//--- testbench/usms_spi_tb.sv
/*
  Self-checking bench of the master SPI port with a slave model.
  Assumes package, design and slave model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module usms_spi_tb;
  import usms_pkg::*;
  logic         CLK = 1'b0, SRST = 1'b1, WR_STB = 1'b0, RD_STB = 1'b0, TXC_CLR = 1'b0, OVR_CLR = 1'b0;
  logic [7:0]   WR_DATA = 8'h00, RD_DATA, got, reply;
  usms_cfg_t    CFG = '0;
  usms_status_t STATUS;
  logic         TXD_OUT, TXD_OE_N, RXD_IN, SCK_OUT, SCK_OE_N, got_stb, auto_rd = 1'b1;
  logic [31:0]  lfsr = 32'hB612677E;
  logic [7:0]   exp_tx[$], exp_rx[$];
  int           n_errors = 0, num_checks = 0;

  always #25 CLK = ~CLK;

  usms_spi u_dut (.CLK(CLK), .SRST(SRST), .CFG(CFG), .WR_STB(WR_STB), .WR_DATA(WR_DATA), .RD_STB(RD_STB),
    .RD_DATA(RD_DATA), .TXC_CLR(TXC_CLR), .OVR_CLR(OVR_CLR), .STATUS(STATUS), .TXD_OUT(TXD_OUT),
    .TXD_OE_N(TXD_OE_N), .RXD_IN(RXD_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N));
  usms_slave u_slave (.clk(CLK), .srst(SRST), .cfg(CFG), .sck(SCK_OUT), .mosi(TXD_OUT), .miso(RXD_IN),
    .got_stb(got_stb), .got(got));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic tick();
    @(posedge CLK);
    #1;
  endtask : tick

  task automatic setup(input logic [1:0] mf, input logic [1:0] sm, input logic lsb, input logic dir,
                       input logic [11:0] div);
    @(posedge CLK);
    SRST  <= 1'b1;
    CFG   <= {mf, 1'b1, 1'b1, sm, lsb, dir, div};
    reply = 8'h3C;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    repeat (4) tick();
    check("sck_oe_n", SCK_OE_N, !(dir && mf == MODE_MSPI));
    check("txd_oe_n", TXD_OE_N, mf != MODE_MSPI);
    check("sck_idle", SCK_OUT, sm[1]);
    check("rd_rst", RD_DATA, 8'h00);
  endtask : setup

  task automatic send(input logic [7:0] b, input logic rx);
    int k;
    k = 0;
    while (STATUS.tx_empty !== 1'b1 && k < 9000)
    begin
      tick();
      k++;
    end
    check("tx_wait", STATUS.tx_empty, 1'b1);
    @(posedge CLK);
    WR_STB  <= 1'b1;
    WR_DATA <= b;
    if (CFG.port_mode_select_field == MODE_MSPI)
    begin
      exp_tx.push_back(b);
      if (rx)
        exp_rx.push_back(reply);
      reply = b ^ 8'h5A;
    end
    @(posedge CLK);
    WR_STB <= 1'b0;
    #1;
    check("txc_mid", STATUS.transmit_complete_flag, 1'b0);
  endtask : send

  task automatic half_period(input logic [31:0] want);
    logic s;
    int   n;
    for (int e = 0; e < 2; e++)
    begin
      s = SCK_OUT;
      n = 0;
      while (SCK_OUT === s && n < 5000)
      begin
        tick();
        n++;
      end
    end
    check("half_period", n, want);
  endtask : half_period

  task automatic finish_batch(input logic cpol);
    int k;
    k = 0;
    while (STATUS.transmit_complete_flag !== 1'b1 && k < 20000)
    begin
      tick();
      k++;
    end
    check("txc", STATUS.transmit_complete_flag, 1'b1);
    check("sck_rest", SCK_OUT, cpol);
    @(posedge CLK);
    TXC_CLR <= 1'b1;
    @(posedge CLK);
    TXC_CLR <= 1'b0;
    repeat (6) tick();
    check("txc_clr", STATUS.transmit_complete_flag, 1'b0);
    check("tx_left", exp_tx.size(), 0);
  endtask : finish_batch

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: slave bytes and receive buffer against the notes
  always @(posedge CLK)
  begin
    if (got_stb === 1'b1)
      check("mosi_byte", got, exp_tx.size() ? exp_tx.pop_front() : 8'hXX);
    RD_STB <= 1'b0;
    if (auto_rd && STATUS.receive_complete_flag === 1'b1 && RD_STB !== 1'b1)
    begin
      check("rx_byte", RD_DATA, exp_rx.size() ? exp_rx.pop_front() : 8'hXX);
      RD_STB <= 1'b1;
    end
  end

  // Run needs about 14k cycles; 80k cycles means a hang
  initial
  begin
    #4000000;
    n_errors++;
    summarize();
  end

  initial
  begin
    logic [11:0] d;
    repeat (2) @(posedge CLK);
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 7) ? 12'h102 : 12'(i % 3 + 1);
      setup(MODE_MSPI, 2'(i), i[2], 1'b1, d);
      send(rnd(), 1'b1);
      half_period(32'(d) + 1);
      send(rnd(), 1'b1);
      send(rnd(), 1'b1);
      finish_batch(i[1]);
      check("rx_left", exp_rx.size(), 0);
    end
    setup(MODE_MSPI, 2'h0, 1'b0, 1'b1, 12'h000);
    @(posedge CLK);
    CFG.receiver_enable_bit <= 1'b0;
    send(rnd(), 1'b0);
    half_period(1);
    finish_batch(1'b0);
    check("rx_off", STATUS.receive_complete_flag, 1'b0);
    for (int m = 0; m < 3; m++)
    begin
      setup(2'(m), 2'h0, 1'b0, 1'b1, 12'h001);
      send(rnd(), 1'b0);
      repeat (6) tick();
      check("inactive_empty", STATUS.tx_empty, 1'b1);
      check("inactive_sck", SCK_OUT, 1'b0);
    end
    setup(MODE_MSPI, 2'h1, 1'b0, 1'b0, 12'h001);
    setup(MODE_MSPI, 2'h1, 1'b0, 1'b1, 12'h002);
    auto_rd = 1'b0;
    for (int b = 0; b < 4; b++)
      send(rnd(), b < 2);
    finish_batch(1'b0);
    check("overrun", STATUS.rx_overrun, 1'b1);
    check("rx_held", STATUS.receive_complete_flag, 1'b1);
    auto_rd = 1'b1;
    repeat (10) tick();
    check("rx_drained", exp_rx.size(), 0);
    @(posedge CLK);
    OVR_CLR <= 1'b1;
    @(posedge CLK);
    OVR_CLR <= 1'b0;
    tick();
    check("ovr_clr", STATUS.rx_overrun, 1'b0);
    summarize();
  end
endmodule : usms_spi_tb
`default_nettype wire
